/* logic/counter_array_module_modes.v */
// Mode selection, capture/compare/PWM per module and interrupt merge for the counter array
// ==========================================================================
//
// Local design decisions: the address map and register access over APB.
`include "counter_array_regs.vh"
`default_nettype none

module counter_array_module_modes #(
    parameter NUM_MODULES = 6,
    parameter CNT_W       = 16
) (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire [`CA_ADDR_W-1:0]  paddr,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [31:0]            pwdata,
    output wire [31:0]            prdata,
    output wire                   pready,
    output wire                   pslverr,
    input  wire [CNT_W-1:0]       counter_value,
    input  wire [1:0]             counter_overflow,
    input  wire [NUM_MODULES-1:0] module_io_pin_in,
    output wire [NUM_MODULES-1:0] module_io_pin_out,
    output wire [NUM_MODULES-1:0] module_io_pin_oe_n,
    output wire                   irq
);

// ==========================================================================
// Register state
reg  [8*NUM_MODULES-1:0]     cfg_q;
reg  [CNT_W*NUM_MODULES-1:0] cmp_q;
wire [CNT_W*NUM_MODULES-1:0] cap_flat;
reg  [7:0]                   status_q;
reg  [7:0]                   status_d;
reg  [7:0]                   enable_q;
reg  [7:0]                   control_q;
reg  [31:0]                  rdata_q;
reg  [31:0]                  rdata_d;
reg                          err_q;
reg                          err_d;
reg                          irq_q;
wire [NUM_MODULES-1:0]       pin_s;
wire [NUM_MODULES-1:0]       chan_evt;
wire [7:0]                   evt_vec;
wire [7:0]                   gate_vec;
wire                         setup;
wire                         wr_acc;
wire [`CA_ADDR_W-1:0]        cfg_off;
wire [`CA_ADDR_W-1:0]        cmp_off;
wire [`CA_ADDR_W-1:0]        cap_off;
wire                         in_cfg;
wire                         in_cmp;
wire                         in_cap;
wire                         aligned;
wire [5:0]                   cfg_idx;
wire [5:0]                   cmp_idx;
wire [5:0]                   cap_idx;

// ==========================================================================
// Pin synchronisers
pin_sync #(
    .WIDTH    (NUM_MODULES)
) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (module_io_pin_in),
    .sync_out (pin_s)
);

// ==========================================================================
// APB decode; the slave never stalls, so pready is tied high
assign pready  = 1'b1;
assign prdata  = rdata_q;
assign pslverr = err_q & psel & penable;
// Decoded once in the setup cycle, so the access phase never has to wait
assign setup   = psel & ~penable;
assign wr_acc  = psel & penable & pwrite & ~err_q;
assign aligned = (paddr[1:0] == 2'h0);
assign cfg_off = paddr - `CA_CFG_BASE;
assign cmp_off = paddr - `CA_CMP_BASE;
assign cap_off = paddr - `CA_CAP_BASE;
assign in_cfg  = aligned && (paddr >= `CA_CFG_BASE) && (paddr < `CA_CFG_BASE + `CA_BANK_SPAN);
assign in_cmp  = aligned && (paddr >= `CA_CMP_BASE) && (paddr < `CA_CMP_BASE + `CA_BANK_SPAN);
assign in_cap  = aligned && (paddr >= `CA_CAP_BASE) && (paddr < `CA_CAP_BASE + `CA_BANK_SPAN);
assign cfg_idx = cfg_off[7:2];
assign cmp_idx = cmp_off[7:2];
assign cap_idx = cap_off[7:2];

// Read data and error are latched in the setup cycle so the access phase sees a flop
always @* begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (!aligned) begin
        err_d = 1'b1;
    end else if (paddr == `CA_STATUS_OFF) begin
        rdata_d[7:0] = status_q;
    end else if (paddr == `CA_CLEAR_OFF) begin
        rdata_d = 32'h0000_0000;
    end else if (paddr == `CA_ENABLE_OFF) begin
        rdata_d[7:0] = enable_q;
    end else if (paddr == `CA_OVF_SET_OFF) begin
        rdata_d = 32'h0000_0000;
    end else if (paddr == `CA_CONTROL_OFF) begin
        rdata_d[7:0] = control_q;
    end else if (in_cfg) begin
        rdata_d[7:0] = cfg_q[cfg_idx*8 +: 8];
    end else if (in_cmp) begin
        rdata_d[CNT_W-1:0] = cmp_q[cmp_idx*CNT_W +: CNT_W];
    end else if (in_cap) begin
        rdata_d[CNT_W-1:0] = cap_flat[cap_idx*CNT_W +: CNT_W];
    end else begin
        err_d = 1'b1;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rdata_q <= 32'h0000_0000;
        err_q   <= 1'b0;
    end else if (setup) begin
        rdata_q <= rdata_d;
        err_q   <= err_d;
    end
end

// ==========================================================================
// Writable registers
// Status and capture slots take no write, yet raise no error either
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_q     <= {NUM_MODULES{`CA_CFG_RESET}};
        cmp_q     <= {NUM_MODULES{`CA_CMP_RESET}};
        enable_q  <= `CA_ENABLE_RESET;
        control_q <= `CA_CONTROL_RESET;
    end else if (wr_acc) begin
        if (paddr == `CA_ENABLE_OFF) begin
            enable_q <= pwdata[7:0];
        end else if (paddr == `CA_CONTROL_OFF) begin
            control_q <= pwdata[7:0];
        end else if (in_cfg) begin
            cfg_q[cfg_idx*8 +: 8] <= pwdata[7:0];
        end else if (in_cmp) begin
            cmp_q[cmp_idx*CNT_W +: CNT_W] <= pwdata[CNT_W-1:0];
        end
    end
end

// ==========================================================================
// Sticky status: hardware or software set wins over a same-cycle clear
always @* begin
    status_d = status_q;
    if (wr_acc && (paddr == `CA_CLEAR_OFF)) begin
        status_d = status_q & ~pwdata[7:0];
    end
    status_d = status_d | evt_vec;
    if (wr_acc && (paddr == `CA_OVF_SET_OFF)) begin
        status_d[`CA_OVF0_BIT] = status_d[`CA_OVF0_BIT] | pwdata[`CA_OVF0_BIT];
        status_d[`CA_OVF1_BIT] = status_d[`CA_OVF1_BIT] | pwdata[`CA_OVF1_BIT];
    end
end

assign evt_vec[`CA_OVF0_BIT]  = counter_overflow[0];
assign evt_vec[`CA_OVF1_BIT]  = counter_overflow[1];
// Overflows pass no module gate; only the enable register masks them
assign gate_vec[`CA_OVF0_BIT] = 1'b1;
assign gate_vec[`CA_OVF1_BIT] = 1'b1;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        status_q <= `CA_STATUS_RESET;
        irq_q    <= 1'b0;
    end else begin
        status_q <= status_d;
        irq_q    <= |(status_q & enable_q & gate_vec);
    end
end

// Registered: one cycle late, but glitch-free toward the processor
assign irq = irq_q;

// ==========================================================================
// Per-module capture, compare, toggle and PWM
genvar m;
generate
    for (m = 0; m < NUM_MODULES; m = m + 1) begin : g_mod
        // Status layout keeps overflow 0 between modules 2 and 3
        localparam integer SP = (m < 3) ? m : m + 1;
        wire [7:0]       cfg;
        wire [CNT_W-1:0] cmp;
        wire [1:0]       pwm_mode;
        wire             cap_mode;
        wire             rise;
        wire             fall;
        wire             cap_evt;
        wire             hit;
        wire             match_evt;
        wire             toggle_mode;
        wire             pwm_on;
        wire             pwm_wave;
        reg              pin_prev_q;
        reg              hit_prev_q;
        reg  [CNT_W-1:0] cap_q;
        reg              toggle_q;
        reg              out_q;
        reg              oe_n_q;

        assign cfg      = cfg_q[m*8 +: 8];
        assign cmp      = cmp_q[m*CNT_W +: CNT_W];
        assign pwm_mode = cfg[`CA_PWM_HI:`CA_PWM_LO];
        assign pwm_on   = cfg[`CA_COMP_EN_BIT] && (pwm_mode != `CA_PWM_OFF);

        // Capture needs the match, toggle and PWM bits all clear
        assign cap_mode = (cfg[`CA_MATCH_BIT:`CA_PWM_LO] == 4'h0);
        assign rise     = pin_s[m] & ~pin_prev_q;
        assign fall     = ~pin_s[m] & pin_prev_q;
        assign cap_evt  = cap_mode && ((cfg[`CA_RISE_CAP_BIT] && rise) ||
                                       (cfg[`CA_FALL_CAP_BIT] && fall));

        // The counter may hold a value for many pclk cycles, so only the first hit counts
        assign hit         = cfg[`CA_COMP_EN_BIT] && cfg[`CA_MATCH_BIT] &&
                             (pwm_mode == `CA_PWM_OFF) && (counter_value == cmp);
        assign match_evt   = hit & ~hit_prev_q;
        assign toggle_mode = cfg[`CA_COMP_EN_BIT] && cfg[`CA_MATCH_BIT] && cfg[`CA_TOGGLE_BIT] &&
                             (pwm_mode == `CA_PWM_OFF);

        // Capture and match never fire together: their mode bits exclude each other
        assign chan_evt[m] = cap_evt | match_evt;
        assign evt_vec[SP] = chan_evt[m];
        assign gate_vec[SP] = cfg[`CA_FIE_BIT];

        // Without the comparator the generator sees mode off and stays idle
        pwm_gen #(
            .CNT_W          (CNT_W)
        ) u_pwm (
            .pclk           (pclk),
            .presetn        (presetn),
            .mode           (cfg[`CA_COMP_EN_BIT] ? pwm_mode : `CA_PWM_OFF),
            .ten_bit_select (control_q[`CA_TEN_BIT_SEL_BIT]),
            .counter_value  (counter_value),
            .compare_value  (cmp),
            .pwm_out        (pwm_wave)
        );

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                // Resets low, the level an idle pin shows, so no false edge follows reset
                pin_prev_q <= 1'b0;
                hit_prev_q <= 1'b0;
                cap_q      <= {CNT_W{1'b0}};
                toggle_q   <= 1'b0;
                out_q      <= 1'b0;
                oe_n_q     <= 1'b1;
            end else begin
                pin_prev_q <= pin_s[m];
                hit_prev_q <= hit;
                if (cap_evt) begin
                    cap_q <= counter_value;
                end
                // Toggle state survives a mode change and resumes from its last level
                if (toggle_mode && match_evt) begin
                    toggle_q <= ~toggle_q;
                end
                if (pwm_on) begin
                    out_q  <= pwm_wave;
                    oe_n_q <= 1'b0;
                end else if (toggle_mode) begin
                    out_q  <= toggle_q;
                    oe_n_q <= 1'b0;
                end else begin
                    out_q  <= 1'b0;
                    oe_n_q <= 1'b1;
                end
            end
        end

        assign cap_flat[m*CNT_W +: CNT_W] = cap_q;
        assign module_io_pin_out[m]       = out_q;
        assign module_io_pin_oe_n[m]      = oe_n_q;
    end
endgenerate

endmodule
`default_nettype wire

/* logic/counter_array_regs.vh */
// Register offsets, field positions and reset values of the counter array mode block
`ifndef COUNTER_ARRAY_REGS_VH
`define COUNTER_ARRAY_REGS_VH

// ==========================================================================
// Register byte offsets
`define CA_ADDR_W            8
`define CA_CFG_BASE          8'h00
`define CA_CMP_BASE          8'h18
`define CA_CAP_BASE          8'h30
`define CA_STATUS_OFF        8'h48
`define CA_CLEAR_OFF         8'h4C
`define CA_ENABLE_OFF        8'h50
`define CA_OVF_SET_OFF       8'h54
`define CA_CONTROL_OFF       8'h58
`define CA_BANK_SPAN         8'h18

// ==========================================================================
// Module function configuration fields
`define CA_FIE_BIT           7
`define CA_COMP_EN_BIT       6
`define CA_RISE_CAP_BIT      5
`define CA_FALL_CAP_BIT      4
`define CA_MATCH_BIT         3
`define CA_TOGGLE_BIT        2
`define CA_PWM_HI            1
`define CA_PWM_LO            0
`define CA_PWM_OFF           2'h0
`define CA_PWM_FIXED8        2'h1
`define CA_PWM_PROG8         2'h2
`define CA_PWM_WIDE          2'h3

// ==========================================================================
// Status, enable and control fields
`define CA_OVF0_BIT          3
`define CA_OVF1_BIT          7
`define CA_TEN_BIT_SEL_BIT   2

// ==========================================================================
// Reset values
`define CA_CFG_RESET         8'h00
`define CA_CMP_RESET         16'h0000
`define CA_STATUS_RESET      8'h00
`define CA_ENABLE_RESET      8'h00
`define CA_CONTROL_RESET     8'h00

`endif

/* logic/pin_sync.v */
// Two-flop synchroniser for the module pin inputs
`default_nettype none

module pin_sync #(
    parameter WIDTH = 6
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

// ==========================================================================
// Stage one is read by stage two only
reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_q <= {WIDTH{1'b0}};
        sync_q <= {WIDTH{1'b0}};
    end else begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end

assign sync_out = sync_q;

endmodule
`default_nettype wire

/* logic/pwm_gen.v */
// PWM waveform generator for one module
`include "counter_array_regs.vh"
`default_nettype none

module pwm_gen #(
    parameter CNT_W = 16
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [1:0]       mode,
    input  wire             ten_bit_select,
    input  wire [CNT_W-1:0] counter_value,
    input  wire [CNT_W-1:0] compare_value,
    output wire             pwm_out
);

// ==========================================================================
// Private period counter for the programmable 8-bit mode
reg [7:0] prog_cnt_q;
reg       cnt_lsb_q;
reg       pwm_q;
reg       pwm_d;
wire      tick;

// Advances once per shared counter step, so the period tracks the counter clock
assign tick = counter_value[0] ^ cnt_lsb_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prog_cnt_q <= 8'h00;
        cnt_lsb_q  <= 1'b0;
    end else begin
        cnt_lsb_q <= counter_value[0];
        if (mode != `CA_PWM_PROG8) begin
            prog_cnt_q <= 8'h00;
        end else if (tick) begin
            if (prog_cnt_q >= compare_value[15:8]) begin
                prog_cnt_q <= 8'h00;
            end else begin
                prog_cnt_q <= prog_cnt_q + 8'h01;
            end
        end
    end
end

// ==========================================================================
// Duty comparison per resolution
always @* begin
    case (mode)
        `CA_PWM_FIXED8: pwm_d = counter_value[7:0] < compare_value[7:0];
        `CA_PWM_PROG8:  pwm_d = prog_cnt_q < compare_value[7:0];
        `CA_PWM_WIDE: begin
            if (ten_bit_select) begin
                pwm_d = counter_value[9:0] < compare_value[9:0];
            end else begin
                pwm_d = counter_value < compare_value;
            end
        end
        default:        pwm_d = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pwm_q <= 1'b0;
    end else begin
        pwm_q <= pwm_d;
    end
end

assign pwm_out = pwm_q;

endmodule
`default_nettype wire

/* test/counter_array_props.sv */
// Port-level assertions for the counter array mode block
`include "counter_array_regs.vh"
`default_nettype none
module counter_array_props #(
    parameter NUM_MODULES = 6,
    parameter CNT_W       = 16
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic [`CA_ADDR_W-1:0]  paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [CNT_W-1:0]       counter_value,
    input wire logic [1:0]             counter_overflow,
    input wire logic [NUM_MODULES-1:0] module_io_pin_in,
    input wire logic [NUM_MODULES-1:0] module_io_pin_out,
    input wire logic [NUM_MODULES-1:0] module_io_pin_oe_n,
    input wire logic                   irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Shadows rebuilt from bus writes
    logic [7:0] cfg0_q;
    logic [7:0] cfg1_q;
    logic [7:0] en_q;
    logic       wr_acc;
    logic       drive1;
    assign wr_acc = psel && penable && pwrite;
    // Pin 1 is driven only in PWM or toggle set-ups; module 1 is the one the bench toggles
    assign drive1 = cfg1_q[6] && (cfg1_q[1:0] != 2'h0 || cfg1_q[3:2] == 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg0_q <= 8'h00;
            cfg1_q <= 8'h00;
            en_q   <= 8'h00;
        end else if (wr_acc && paddr == `CA_CFG_BASE) begin
            cfg0_q <= pwdata[7:0];
        end else if (wr_acc && paddr == `CA_CFG_BASE + 8'h04) begin
            cfg1_q <= pwdata[7:0];
        end else if (wr_acc && paddr == `CA_ENABLE_OFF) begin
            en_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Assertions
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    unmapped_err_a: assert property (psel && penable && (paddr > `CA_CONTROL_OFF || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    reset_quiet_a: assert property ($rose(presetn) |-> &module_io_pin_oe_n && module_io_pin_out == '0 && !irq)
        else $error("pins or irq active after reset");
    overflow_irq_a: assert property (|(counter_overflow & {en_q[7], en_q[3]}) |-> ##[1:2] irq)
        else $error("enabled overflow gave no irq");
    irq_masked_a: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq)
        else $error("irq with every source masked");
    cfg_read_a: assert property (psel && penable && !pwrite && paddr == `CA_CFG_BASE |-> prdata == {24'h0, cfg0_q})
        else $error("configuration 0 read wrong");
    pin_drive_a: assert property (!module_io_pin_oe_n[1] |-> drive1 || $past(drive1))
        else $error("pin 1 driven outside PWM or toggle");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("irq fell without a bus write");
    irq_cov: cover property ($rose(irq));
    refuse_cov: cover property (pslverr);
    toggle_cov: cover property ($changed(module_io_pin_out[1]));
endmodule
bind counter_array_module_modes counter_array_props #(.NUM_MODULES(NUM_MODULES), .CNT_W(CNT_W)) props_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_value(counter_value), .counter_overflow(counter_overflow),
    .module_io_pin_in(module_io_pin_in), .module_io_pin_out(module_io_pin_out),
    .module_io_pin_oe_n(module_io_pin_oe_n), .irq(irq)
);
`default_nettype wire

/* test/pin_side_model.sv */
// External pin model: capture edge source and output receiver
`default_nettype none
module pin_side_model #(
    parameter NUM_MODULES = 6
) (
    input  wire logic [NUM_MODULES-1:0] pin_out,
    input  wire logic [NUM_MODULES-1:0] pin_oe_n,
    output wire logic [NUM_MODULES-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Wire level: block wins where it drives, external level elsewhere
    logic [NUM_MODULES-1:0] drive_lvl = '0;
    assign pin_in = (pin_out & ~pin_oe_n) | (drive_lvl & pin_oe_n);
endmodule
`default_nettype wire

/* test/tb_counter_array_module_modes.sv */
// Self-checking bench for the counter array mode block
`include "counter_array_regs.vh"
`default_nettype none
module tb_counter_array_module_modes;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] counter_value = 16'h0000;
    logic [1:0]  counter_overflow = 2'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pin_in;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe_n;
    logic        irq;
    logic [31:0] rd;
    logic        err_seen;
    int          bad_count = 0;
    int          check_count = 0;
    // Capture set-ups, then PWM rows {cfg, control, compare, counter}
    logic [7:0]  cap_cfg [3] = '{8'h20, 8'h10, 8'h30};
    logic [5:0]  cap_exp = 6'b111001;
    logic [47:0] pr [5] = '{48'h41_00_0080_0010, 48'h41_00_0080_0190, 48'h43_00_0100_0400,
                             48'h43_04_0100_0400, 48'h42_00_8040_0000};
    logic [4:0]  pe = 5'b11001;
    always #12.5 pclk = ~pclk;
    counter_array_module_modes uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_value(counter_value), .counter_overflow(counter_overflow),
        .module_io_pin_in(pin_in), .module_io_pin_out(pin_out), .module_io_pin_oe_n(pin_oe_n), .irq(irq)
    );
    pin_side_model ext (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
    // ==========================================================
    // Tasks
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // Request held until pready is seen high; no fixed wait assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                bad_count++;
                $display("Error at %0t: no pready", $time);
                stop_test();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v) begin
            @(posedge pclk);
            n++;
            if (n > 20) begin
                bad_count++;
                $display("Error at %0t: irq wait", $time);
                stop_test();
            end
        end
        check_count++;
    endtask
    // Counter equals compare 1 for exactly one cycle
    task automatic hit;
        counter_value <= 16'h0010;
        @(posedge pclk);
        counter_value <= 16'h0011;
        cyc(4);
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rchk(8'(4 * i), 32'h0);
            apb(1'b1, 8'(4 * i), 32'h30 | i);
            rchk(8'(4 * i), 32'h30 | i);
            apb(1'b1, 8'(4 * i), 32'h0);
        end
        rchk(`CA_STATUS_OFF, 32'h0);
        apb(1'b0, 8'h5C, 32'h0);
        check(err_seen, 1'b1);
        apb(1'b0, 8'h01, 32'h0);
        check(err_seen, 1'b1);
        // Each capture set-up sees a rising then a falling edge
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, `CA_CFG_BASE, 32'(cap_cfg[m]));
            for (int e = 0; e < 2; e++) begin
                counter_value <= 16'h1000 + 16'(m * 16 + e);
                ext.drive_lvl[0] <= (e == 0);
                cyc(6);
                rchk(`CA_STATUS_OFF, 32'(cap_exp[m * 2 + e]));
                if (cap_exp[m * 2 + e]) begin
                    rchk(`CA_CAP_BASE, 32'h1000 + 32'(m * 16 + e));
                end
                apb(1'b1, `CA_CLEAR_OFF, 32'h01);
            end
        end
        apb(1'b1, `CA_ENABLE_OFF, 32'h88);
        counter_overflow <= 2'h1;
        @(posedge pclk);
        counter_overflow <= 2'h0;
        wait_irq(1'b1);
        rchk(`CA_STATUS_OFF, 32'h08);
        apb(1'b1, `CA_CLEAR_OFF, 32'h08);
        wait_irq(1'b0);
        apb(1'b1, `CA_OVF_SET_OFF, 32'h80);
        rchk(`CA_STATUS_OFF, 32'h80);
        wait_irq(1'b1);
        apb(1'b1, `CA_CLEAR_OFF, 32'h80);
        // Module flag stays silent with its enable register bit set, until its FIE bit in the configuration is set too
        apb(1'b1, `CA_ENABLE_OFF, 32'h01);
        apb(1'b1, `CA_CFG_BASE, 32'h20);
        ext.drive_lvl[0] <= 1'b1;
        cyc(6);
        check(irq, 1'b0);
        rchk(`CA_STATUS_OFF, 32'h01);
        apb(1'b1, `CA_CFG_BASE, 32'hA0);
        wait_irq(1'b1);
        apb(1'b1, `CA_CLEAR_OFF, 32'h01);
        wait_irq(1'b0);
        apb(1'b1, `CA_CFG_BASE, 32'h00);
        ext.drive_lvl[0] <= 1'b0;
        // Toggle, then software timer, on module 1
        apb(1'b1, `CA_CMP_BASE + 8'h04, 32'h0010);
        apb(1'b1, `CA_CFG_BASE + 8'h04, 32'h4C);
        hit();
        check(pin_oe_n[1], 1'b0);
        check(pin_out[1], 1'b1);
        rchk(`CA_STATUS_OFF, 32'h02);
        apb(1'b1, `CA_CLEAR_OFF, 32'h02);
        hit();
        check(pin_out[1], 1'b0);
        apb(1'b1, `CA_CLEAR_OFF, 32'h02);
        apb(1'b1, `CA_CFG_BASE + 8'h04, 32'h48);
        hit();
        rchk(`CA_STATUS_OFF, 32'h02);
        check(pin_oe_n[1], 1'b1);
        apb(1'b1, `CA_CLEAR_OFF, 32'h02);
        apb(1'b1, `CA_CFG_BASE + 8'h04, 32'h00);
        // PWM on module 2; wide rows differ only in the width select
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `CA_CONTROL_OFF, 32'(pr[i][39:32]));
            apb(1'b1, `CA_CMP_BASE + 8'h08, 32'(pr[i][31:16]));
            apb(1'b1, `CA_CFG_BASE + 8'h08, 32'(pr[i][47:40]));
            counter_value <= pr[i][15:0];
            cyc(4);
            check(pin_oe_n[2], 1'b0);
            check(pin_out[2], pe[i]);
        end
        // Programmable mode: duty 0x40 steps ends well before the 0x81-step period wraps
        for (int k = 1; k <= 70; k++) begin
            counter_value <= 16'(k);
            @(posedge pclk);
        end
        check(pin_out[2], 1'b0);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("Error at %0t: run timed out", $time);
        stop_test();
    end
endmodule
`default_nettype wire
